// File: dcs_pkg.sv
package dcs_pkg;
   // register byte addresses (printed offsets 0x00, 0x01 are indices)
   localparam logic [3:0] DCS_IDX_PRIMARY = 4'h0;
   localparam logic [3:0] DCS_IDX_SECONDARY = 4'h1;
   localparam logic [3:0] DCS_IDX_SYNC = 4'h2;
   localparam logic [5:0] DCS_ADDR_PRIMARY = {DCS_IDX_PRIMARY, 2'b00};
   localparam logic [5:0] DCS_ADDR_SECONDARY = {DCS_IDX_SECONDARY, 2'b00};
   localparam logic [5:0] DCS_ADDR_SYNC = {DCS_IDX_SYNC, 2'b00};
   // primary_control fields
   localparam int DCS_BIT_SOFT_RESET = 0;
   localparam int DCS_BIT_ENABLE = 1;
   localparam int DCS_BIT_STANDBY_RUN = 6;
   localparam logic [7:0] DCS_PRIMARY_MASK = 8'h43;
   // sync_pending_flags fields
   localparam int DCS_SYNC_SOFT_RESET = 0;
   localparam int DCS_SYNC_ENABLE = 1;
   // reset values
   localparam logic [7:0] DCS_PRIMARY_RESET = 8'h00;
   localparam logic [7:0] DCS_SECONDARY_RESET = 8'h00;
   // converter-side handshake length in cycles
   localparam logic [2:0] DCS_SYNC_CYCLES = 3'h4;
   localparam logic [1:0] DCS_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCS_RESP_SLVERR = 2'h2;
endpackage

// File: dcs_sync_chan.sv
module dcs_sync_chan
   import dcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   output logic busy,
   output logic done
);
   // request toggles out, delayed ack returns through two flops
   logic req;
   logic [2:0] cnt;
   logic ack_src;
   logic ack_s1;
   logic ack_s2;
   logic ack_seen;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         req <= 1'b0;
      else if (start && !busy)
         req <= ~req;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt <= 3'h0;
         ack_src <= 1'b0;
      end
      else if (req != ack_src)
      begin
         if (cnt == DCS_SYNC_CYCLES - 3'h1)
         begin
            cnt <= 3'h0;
            ack_src <= req;
         end
         else
            cnt <= cnt + 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_seen <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack_src;
         ack_s2 <= ack_s1;
         ack_seen <= ack_s2;
      end
   end

   assign busy = (req != ack_seen);
   assign done = (ack_s2 != ack_seen);
endmodule

// File: dcs_axil_if.sv
module dcs_axil_if
   import dcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_stb,
   output logic [5:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_ok,
   output logic [5:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_ok
);
   logic aw_held;
   logic w_held;
   logic [7:0] w_byte;
   logic w_lane0;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_stb = aw_held && w_held && w_lane0 && !s_axi_bvalid;
   assign wr_data = w_byte;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 6'h00;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DCS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (aw_held && w_held && !s_axi_bvalid)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? DCS_RESP_OKAY : DCS_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= DCS_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_ok ? rd_data : 8'h00};
         s_axi_rresp <= rd_ok ? DCS_RESP_OKAY : DCS_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// File: dcs_top.sv
// Function
// - standby_run 0 turns output buffer off in standby; 1 lets it stay on
// - standby_run write takes effect at once, no busy flag
// - enable bit reads back the written value immediately
// - enable write sets enable busy flag; cleared when operation completes (here only a write that changes enable sets it)
// - enable read 1 means enabled or enabling, 0 disabled or disabling
// - writing 0 to soft_reset_request does nothing
// - writing 1 to soft_reset_request resets all registers, converter disabled
// - a write with soft_reset_request set discards its other fields
// - reset bit and reset busy flag read 1 until reset completes
//
// Our own choice: the AXI4-Lite register port.
module dcs_top
   import dcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic standby,
   output logic converter_enabled,
   output logic buffer_on,
   output logic [7:0] secondary_control
);
   logic wr_stb;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_ok;
   logic [5:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_ok;
   logic standby_s1;
   logic standby_s2;
   logic standby_run;
   logic enable;
   logic soft_reset_request;
   logic en_start;
   logic en_busy;
   logic en_done;
   logic rs_start;
   logic rs_busy;
   logic rs_done;
   logic en_target;

   function automatic logic addr_known(input logic [5:0] a);
      addr_known = (a == DCS_ADDR_PRIMARY) || (a == DCS_ADDR_SECONDARY)
         || (a == DCS_ADDR_SYNC);
   endfunction

   dcs_axil_if u_bus (
      .mclk(mclk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   assign wr_ok = addr_known(wr_addr);
   assign rd_ok = addr_known(rd_addr);

   // writes to control are ignored while a soft reset is pending
   logic prim_wr;
   logic sec_wr;
   logic new_reset;
   assign prim_wr = wr_stb && (wr_addr == DCS_ADDR_PRIMARY) && !soft_reset_request;
   assign sec_wr = wr_stb && (wr_addr == DCS_ADDR_SECONDARY) && !soft_reset_request;
   assign new_reset = prim_wr && wr_data[DCS_BIT_SOFT_RESET];

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         standby_s1 <= 1'b0;
         standby_s2 <= 1'b0;
      end
      else
      begin
         standby_s1 <= standby;
         standby_s2 <= standby_s1;
      end
   end

   // standby_run and secondary apply directly
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         standby_run <= DCS_PRIMARY_RESET[DCS_BIT_STANDBY_RUN];
         secondary_control <= DCS_SECONDARY_RESET;
      end
      else if (rs_done)
      begin
         standby_run <= DCS_PRIMARY_RESET[DCS_BIT_STANDBY_RUN];
         secondary_control <= DCS_SECONDARY_RESET;
      end
      else
      begin
         if (prim_wr && !new_reset)
            standby_run <= wr_data[DCS_BIT_STANDBY_RUN];
         if (sec_wr)
            secondary_control <= wr_data;
      end
   end

   // enable reads back at once; hardware side follows later
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         enable <= 1'b0;
      else if (new_reset || rs_done)
         enable <= 1'b0;
      else if (prim_wr)
         enable <= wr_data[DCS_BIT_ENABLE];
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         soft_reset_request <= 1'b0;
      else if (new_reset)
         soft_reset_request <= 1'b1;
      else if (rs_done)
         soft_reset_request <= 1'b0;
   end

   // only a change of enable launches handshake; changes during busy relaunch after
   logic en_pend;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         en_pend <= 1'b0;
      else if (new_reset)
         en_pend <= 1'b0;
      else if (prim_wr && (wr_data[DCS_BIT_ENABLE] != enable))
         en_pend <= 1'b1;
      else if (en_start && !en_busy)
         en_pend <= 1'b0;
   end
   assign en_start = en_pend;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         en_target <= 1'b0;
      else if (en_start && !en_busy)
         en_target <= enable;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         converter_enabled <= 1'b0;
      else if (rs_done)
         converter_enabled <= 1'b0;
      else if (en_done)
         converter_enabled <= en_target;
   end

   assign rs_start = new_reset;

   dcs_sync_chan u_en_sync (
      .mclk(mclk),
      .rst(rst),
      .start(en_start),
      .busy(en_busy),
      .done(en_done)
   );

   dcs_sync_chan u_rs_sync (
      .mclk(mclk),
      .rst(rst),
      .start(rs_start),
      .busy(rs_busy),
      .done(rs_done)
   );

   // output buffer follows converter and standby policy
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         buffer_on <= 1'b0;
      else
         buffer_on <= converter_enabled && (!standby_s2 || standby_run);
   end

   always_comb
   begin
      rd_data = 8'h00;
      case (rd_addr)
         DCS_ADDR_PRIMARY:
         begin
            rd_data[DCS_BIT_STANDBY_RUN] = standby_run;
            rd_data[DCS_BIT_ENABLE] = enable;
            rd_data[DCS_BIT_SOFT_RESET] = soft_reset_request;
         end
         DCS_ADDR_SECONDARY: rd_data = secondary_control;
         DCS_ADDR_SYNC:
         begin
            rd_data[DCS_SYNC_ENABLE] = en_busy || en_pend;
            rd_data[DCS_SYNC_SOFT_RESET] = soft_reset_request;
         end
         default: rd_data = 8'h00;
      endcase
   end

   property p_reset_blocks_enable;
      @(posedge mclk) disable iff (rst)
      new_reset |=> !enable;
   endproperty
   a_reset_blocks_enable: assert property (p_reset_blocks_enable)
      else $error("enable survived soft reset");
   property p_std_direct;
      @(posedge mclk) disable iff (rst)
      (prim_wr && !new_reset && !rs_done) |=> standby_run == $past(wr_data[DCS_BIT_STANDBY_RUN]);
   endproperty
   a_std_direct: assert property (p_std_direct) else $error("standby_run late");
   property p_en_readback;
      @(posedge mclk) disable iff (rst)
      (prim_wr && !new_reset && !rs_done) |=> enable == $past(wr_data[DCS_BIT_ENABLE]);
   endproperty
   a_en_readback: assert property (p_en_readback) else $error("enable readback wrong");
   property p_en_busy;
      @(posedge mclk) disable iff (rst)
      prim_wr && !new_reset && (wr_data[DCS_BIT_ENABLE] != enable) |=> (en_pend || en_busy);
   endproperty
   a_en_busy: assert property (p_en_busy) else $error("enable busy not set");
   property p_en_done_bound;
      @(posedge mclk) disable iff (rst)
      $rose(en_busy) |-> ##[1:12] !en_busy;
   endproperty
   a_en_done_bound: assert property (p_en_done_bound) else $error("enable sync hung");
   property p_rs_hold;
      @(posedge mclk) disable iff (rst)
      new_reset |=> soft_reset_request [*4];
   endproperty
   a_rs_hold: assert property (p_rs_hold) else $error("reset bit dropped early");
   property p_rs_done;
      @(posedge mclk) disable iff (rst)
      new_reset |-> ##[2:12] rs_done ##1 (!soft_reset_request && !enable && !standby_run);
   endproperty
   a_rs_done: assert property (p_rs_done) else $error("soft reset incomplete");
   property p_zero_noop;
      @(posedge mclk) disable iff (rst)
      (prim_wr && !wr_data[DCS_BIT_SOFT_RESET] && !soft_reset_request) |=> !soft_reset_request;
   endproperty
   a_zero_noop: assert property (p_zero_noop) else $error("zero write started reset");
   property p_buf;
      @(posedge mclk) disable iff (rst)
      (standby_s2 && !standby_run) |=> !buffer_on;
   endproperty
   a_buf: assert property (p_buf) else $error("buffer on in standby");
   property p_state;
      @(posedge mclk) disable iff (rst)
      en_done |=> converter_enabled == $past(en_target) || $past(rs_done);
   endproperty
   a_state: assert property (p_state) else $error("converter state mismatch");
   property p_rs_flag;
      @(posedge mclk) disable iff (rst)
      soft_reset_request == rs_busy;
   endproperty
   a_rs_flag: assert property (p_rs_flag) else $error("reset bit and busy differ");
   property p_rs_bound;
      @(posedge mclk) disable iff (rst)
      $rose(rs_busy) |-> ##[1:12] !rs_busy;
   endproperty
   a_rs_bound: assert property (p_rs_bound) else $error("reset sync hung");
   c_enable: cover property (@(posedge mclk) $rose(converter_enabled));
   c_reset: cover property (@(posedge mclk) rs_done);
   c_standby: cover property (@(posedge mclk) standby_s2 && buffer_on);
   c_buf_off: cover property (@(posedge mclk) standby_s2 && converter_enabled && !buffer_on);
endmodule

// File: dcs_top_tb.sv
module dcs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dcs_pkg::*;

   logic mclk;
   logic rst;
   logic [5:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [5:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic standby;
   logic converter_enabled;
   logic buffer_on;
   logic [7:0] secondary_control;
   int n_fail;
   int cmp_count;
   logic [31:0] rv;
   logic [1:0] rr;

   dcs_top i_dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .standby(standby),
      .converter_enabled(converter_enabled), .buffer_on(buffer_on),
      .secondary_control(secondary_control));

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask

   // ready sampled at the falling edge equals its value at the next rising edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah;
      logic wh;
      logic bh;
      logic [1:0] r;
      int n;
      ah = 1'b0;
      wh = 1'b0;
      bh = 1'b0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!bh && n < 100)
      begin
         @(negedge mclk);
         if (s_axi_awvalid && s_axi_awready) ah = 1'b1;
         if (s_axi_wvalid && s_axi_wready) wh = 1'b1;
         bh = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge mclk);
         if (ah && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (wh && s_axi_wvalid) s_axi_wvalid <= 1'b0;
         n++;
      end
      chk("write response", {30'h0, er}, {30'h0, r});
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah;
      logic dh;
      int n;
      ah = 1'b0;
      dh = 1'b0;
      n = 0;
      d = 32'hFFFFFFFF;
      r = 2'h3;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!dh && n < 100)
      begin
         @(negedge mclk);
         if (s_axi_arvalid && s_axi_arready) ah = 1'b1;
         dh = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge mclk);
         if (ah && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         n++;
      end
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er,
                         input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, exp, d);
      chk({nm, " response"}, {30'h0, er}, {30'h0, r});
   endtask

   // poll a register until it shows the expected value, bounded
   task automatic wait_reg(input logic [5:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      d = ~exp;
      while (d !== exp && n < 50)
      begin
         rd(a, d, r);
         n++;
      end
      chk(nm, exp, d);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      close_out();
   end

   initial
   begin
      rst = 1'b1;
      s_axi_awaddr = 6'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 6'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      standby = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd_chk(DCS_ADDR_PRIMARY, {24'h0, DCS_PRIMARY_RESET}, DCS_RESP_OKAY, "primary");
      rd_chk(DCS_ADDR_SECONDARY, {24'h0, DCS_SECONDARY_RESET}, DCS_RESP_OKAY, "secondary");
      rd_chk(DCS_ADDR_SYNC, 32'h0, DCS_RESP_OKAY, "sync flags");
      rd_chk(6'h0C, 32'h0, DCS_RESP_SLVERR, "unmapped");
      wr(6'h0C, 32'hFF, DCS_RESP_SLVERR);
      $display("test reset_values done");
      wr(DCS_ADDR_PRIMARY, 32'h40, DCS_RESP_OKAY);
      rd_chk(DCS_ADDR_PRIMARY, 32'h40, DCS_RESP_OKAY, "primary");
      rd_chk(DCS_ADDR_SYNC, 32'h0, DCS_RESP_OKAY, "sync flags");
      $display("test standby_run done");
      wr(DCS_ADDR_PRIMARY, 32'h42, DCS_RESP_OKAY);
      rd_chk(DCS_ADDR_PRIMARY, 32'h42, DCS_RESP_OKAY, "primary");
      rd_chk(DCS_ADDR_SYNC, 32'h2, DCS_RESP_OKAY, "enable busy");
      chk("converter_enabled", 32'h0, {31'h0, converter_enabled});
      wait_reg(DCS_ADDR_SYNC, 32'h0, "enable busy cleared");
      chk("converter_enabled", 32'h1, {31'h0, converter_enabled});
      chk("buffer_on", 32'h1, {31'h0, buffer_on});
      standby <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("buffer_on", 32'h1, {31'h0, buffer_on});
      wr(DCS_ADDR_PRIMARY, 32'h02, DCS_RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk("buffer_on", 32'h0, {31'h0, buffer_on});
      standby <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("buffer_on", 32'h1, {31'h0, buffer_on});
      $display("test enable_standby done");
      wr(DCS_ADDR_SECONDARY, 32'hA5, DCS_RESP_OKAY);
      rd_chk(DCS_ADDR_SECONDARY, 32'hA5, DCS_RESP_OKAY, "secondary");
      chk("secondary_control", 32'hA5, {24'h0, secondary_control});
      wr(DCS_ADDR_PRIMARY, 32'h42, DCS_RESP_OKAY);
      wait_reg(DCS_ADDR_SYNC, 32'h0, "sync flags");
      rd_chk(DCS_ADDR_PRIMARY, 32'h42, DCS_RESP_OKAY, "primary");
      chk("converter_enabled", 32'h1, {31'h0, converter_enabled});
      $display("test no_reset_on_zero done");
      wr(DCS_ADDR_PRIMARY, 32'h01, DCS_RESP_OKAY);
      rd(DCS_ADDR_PRIMARY, rv, rr);
      chk("reset bit", 32'h1, {31'h0, rv[0]});
      chk("reset bit response", {30'h0, DCS_RESP_OKAY}, {30'h0, rr});
      wait_reg(DCS_ADDR_PRIMARY, 32'h0, "primary after reset");
      rd_chk(DCS_ADDR_SYNC, 32'h0, DCS_RESP_OKAY, "reset busy");
      rd_chk(DCS_ADDR_SECONDARY, 32'h0, DCS_RESP_OKAY, "secondary");
      chk("secondary_control", 32'h0, {24'h0, secondary_control});
      chk("converter_enabled", 32'h0, {31'h0, converter_enabled});
      chk("buffer_on", 32'h0, {31'h0, buffer_on});
      $display("test soft_reset done");
      wr(DCS_ADDR_PRIMARY, 32'h43, DCS_RESP_OKAY);
      rd_chk(DCS_ADDR_PRIMARY, 32'h01, DCS_RESP_OKAY, "primary");
      rd_chk(DCS_ADDR_SYNC, 32'h01, DCS_RESP_OKAY, "reset busy");
      wait_reg(DCS_ADDR_PRIMARY, 32'h0, "primary after reset");
      rd_chk(DCS_ADDR_SYNC, 32'h0, DCS_RESP_OKAY, "sync flags");
      chk("converter_enabled", 32'h0, {31'h0, converter_enabled});
      $display("test reset_precedence done");
      close_out();
   end
endmodule
